/* design/uart_presc_pkg.sv */
package uart_presc_pkg;

  // register offsets (byte addresses on the plain register port)
  localparam logic [3:0] STATUS_OFS        = 4'h0;
  localparam logic [3:0] DATA_OFS          = 4'h1;
  localparam logic [3:0] BAUD_MID_OFS      = 4'h2;
  localparam logic [3:0] BAUD_HL_OFS       = 4'h3;
  localparam logic [3:0] FRAME_CTRL_OFS    = 4'h4;
  localparam logic [3:0] XFER_CTRL_OFS     = 4'h5;
  localparam logic [3:0] STOP_CLK_CTRL_OFS = 4'h6;
  localparam logic [3:0] BRK_ADDR_CTRL_OFS = 4'h7;
  localparam logic [3:0] SPECIAL_CTRL_OFS  = 4'h8;
  localparam logic [3:0] LIN_SLAVE_OFS     = 4'h9;
  localparam logic [3:0] GUARD_OFS_I1      = 4'h9;
  localparam logic [3:0] GUARD_OFS_I2      = 4'hA;
  localparam logic [3:0] PRESC_OFS_I1      = 4'hA;
  localparam logic [3:0] PRESC_OFS_I2      = 4'hB;

  // reset values
  localparam logic [7:0] STATUS_RST        = 8'hC0;
  localparam logic [7:0] CTRL_RST          = 8'h00;
  localparam logic [7:0] PRESC_RST         = 8'h00;

  // field positions in special_mode_control
  localparam int SMARTCARD_ENABLE_BIT  = 5;
  localparam int PARITY_NEGATIVE_ACK_ENABLE_BIT  = 4;
  localparam int SINGLE_WIRE_SELECT_BIT = 3;
  localparam int INFRARED_LOW_POWER_BIT  = 2;
  localparam int INFRARED_ENABLE_BIT  = 1;

  // writable masks of the mode, stop/clock, break/address and LIN slave registers
  localparam logic [7:0] SPECIAL_MASK_FULL = 8'h3E;
  localparam logic [7:0] SPECIAL_MASK_I2   = 8'h36;
  localparam logic [7:0] STOP_CLK_MASK     = 8'h7F;
  localparam logic [7:0] STOP_CLK_MASK_I3  = 8'h70;
  localparam logic [7:0] BRK_ADDR_MASK     = 8'h7F;
  localparam logic [7:0] LIN_SLAVE_MASK    = 8'hB7;

  // smartcard divisor field width and multiplier
  localparam int SC_BITS     = 5;
  localparam int SC_MULT_SHL = 1;

endpackage

/* design/presc_divider.sv */
`timescale 1ns/1ps
`default_nettype none

module presc_divider
  import uart_presc_pkg::*;
(
  // clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_n,
  // control
  input  wire logic       i_run,
  input  wire logic [8:0] i_divisor,
  // output
  output var  logic       o_tick
);

  logic [8:0] cnt_reg;
  logic [8:0] cnt_next;
  logic       tick_reg;
  logic       tick_next;

  // reload counter: one tick per completed count of divisor cycles
  always_comb begin
    cnt_next  = cnt_reg;
    tick_next = 1'b0;
    if (!i_run || i_divisor == 9'h000) begin
      cnt_next = 9'h000;
    end else if (cnt_reg + 9'h001 >= i_divisor) begin
      cnt_next  = 9'h000;
      tick_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + 9'h001;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg  <= 9'h000;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign o_tick = tick_reg;

endmodule

`default_nettype wire

/* design/uart_presc_regs.sv */
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module uart_presc_regs
  import uart_presc_pkg::*;
#(
  // 1, 2 or 3: selects which instance map is built
  parameter int INSTANCE = 2
)(
  // clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_n,
  // register port
  input  wire logic [3:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output var  logic [7:0] o_rdata,
  // hardware status from the serial core
  input  wire logic [7:0] i_status,
  input  wire logic [7:0] i_rx_data,
  // mode outputs
  output var  logic       o_infrared_enable,
  output var  logic       o_infrared_low_power,
  output var  logic       o_smartcard_enable,
  output var  logic       o_parity_negative_ack_enable,
  output var  logic       o_single_wire_select,
  output var  logic       o_lin_enable,
  output var  logic [7:0] o_guard_time_value,
  output var  logic [15:0] o_baud_div,
  // prescaled clocks as one-cycle enables
  output var  logic       o_irda_lp_tick,
  output var  logic       o_smartcard_tick
);

  localparam bit HAS_PSC = (INSTANCE != 3);
  localparam bit HAS_LIN = (INSTANCE == 2);
  localparam logic [3:0] PRESC_OFS = (INSTANCE == 1) ? PRESC_OFS_I1
                                                     : PRESC_OFS_I2;
  localparam logic [3:0] GUARD_OFS = (INSTANCE == 1) ? GUARD_OFS_I1
                                                     : GUARD_OFS_I2;
  localparam logic [7:0] SPEC_MASK = (INSTANCE == 2) ? SPECIAL_MASK_I2
                                                     : SPECIAL_MASK_FULL;
  localparam logic [7:0] SC_MASK   = (INSTANCE == 3) ? STOP_CLK_MASK_I3
                                                     : STOP_CLK_MASK;

  ////////////////////////////////////////////////////////////////////////
  // register file

  logic [7:0] tx_data_reg,  tx_data_next;
  logic [7:0] baud_mid_reg, baud_mid_next;
  logic [7:0] baud_hl_reg,  baud_hl_next;
  logic [7:0] frame_reg,    frame_next;
  logic [7:0] xfer_reg,     xfer_next;
  logic [7:0] stopclk_reg,  stopclk_next;
  logic [7:0] brkaddr_reg,  brkaddr_next;
  logic [7:0] special_reg,  special_next;
  logic [7:0] lin_reg,      lin_next;
  logic [7:0] guard_reg,    guard_next;
  logic [7:0] presc_reg,    presc_next;
  logic [7:0] rdata_reg,    rdata_next;

  always_comb begin
    tx_data_next  = tx_data_reg;
    baud_mid_next = baud_mid_reg;
    baud_hl_next  = baud_hl_reg;
    frame_next    = frame_reg;
    xfer_next     = xfer_reg;
    stopclk_next  = stopclk_reg;
    brkaddr_next  = brkaddr_reg;
    special_next  = special_reg;
    lin_next      = lin_reg;
    guard_next    = guard_reg;
    presc_next    = presc_reg;
    if (i_wr) begin
      if (i_addr == DATA_OFS)          tx_data_next  = i_wdata;
      if (i_addr == BAUD_MID_OFS)      baud_mid_next = i_wdata;
      if (i_addr == BAUD_HL_OFS)       baud_hl_next  = i_wdata;
      if (i_addr == FRAME_CTRL_OFS)    frame_next    = i_wdata;
      if (i_addr == XFER_CTRL_OFS)     xfer_next     = i_wdata;
      if (i_addr == STOP_CLK_CTRL_OFS) stopclk_next  = i_wdata & SC_MASK;
      if (i_addr == BRK_ADDR_CTRL_OFS) brkaddr_next  = i_wdata & BRK_ADDR_MASK;
      // third instance keeps this offset reserved
      if (HAS_PSC && i_addr == SPECIAL_CTRL_OFS) begin
        special_next = i_wdata & SPEC_MASK;
      end
      if (HAS_LIN && i_addr == LIN_SLAVE_OFS) begin
        lin_next = i_wdata & LIN_SLAVE_MASK;
      end
      if (HAS_PSC && i_addr == GUARD_OFS) guard_next = i_wdata;
      if (HAS_PSC && i_addr == PRESC_OFS) begin
        presc_next = i_wdata;
      end
    end
  end

  // read mux; unmapped and reserved offsets read zero
  always_comb begin
    rdata_next = rdata_reg;
    if (i_rd) begin
      rdata_next = 8'h00;
      if (i_addr == STATUS_OFS)        rdata_next = i_status;
      if (i_addr == DATA_OFS)          rdata_next = i_rx_data;
      if (i_addr == BAUD_MID_OFS)      rdata_next = baud_mid_reg;
      if (i_addr == BAUD_HL_OFS)       rdata_next = baud_hl_reg;
      if (i_addr == FRAME_CTRL_OFS)    rdata_next = frame_reg;
      if (i_addr == XFER_CTRL_OFS)     rdata_next = xfer_reg;
      if (i_addr == STOP_CLK_CTRL_OFS) rdata_next = stopclk_reg;
      if (i_addr == BRK_ADDR_CTRL_OFS) rdata_next = brkaddr_reg;
      if (HAS_PSC && i_addr == SPECIAL_CTRL_OFS) rdata_next = special_reg;
      if (HAS_LIN && i_addr == LIN_SLAVE_OFS)    rdata_next = lin_reg;
      if (HAS_PSC && i_addr == GUARD_OFS)        rdata_next = guard_reg;
      if (HAS_PSC && i_addr == PRESC_OFS)        rdata_next = presc_reg;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_data_reg  <= CTRL_RST;
      baud_mid_reg <= CTRL_RST;
      baud_hl_reg  <= CTRL_RST;
      frame_reg    <= CTRL_RST;
      xfer_reg     <= CTRL_RST;
      stopclk_reg  <= CTRL_RST;
      brkaddr_reg  <= CTRL_RST;
      special_reg  <= CTRL_RST;
      lin_reg      <= CTRL_RST;
      guard_reg    <= CTRL_RST;
      presc_reg    <= PRESC_RST;
      rdata_reg    <= 8'h00;
    end else begin
      tx_data_reg  <= tx_data_next;
      baud_mid_reg <= baud_mid_next;
      baud_hl_reg  <= baud_hl_next;
      frame_reg    <= frame_next;
      xfer_reg     <= xfer_next;
      stopclk_reg  <= stopclk_next;
      brkaddr_reg  <= brkaddr_next;
      special_reg  <= special_next;
      lin_reg      <= lin_next;
      guard_reg    <= guard_next;
      presc_reg    <= presc_next;
      rdata_reg    <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // prescaler divisors

  logic       irda_run;
  logic       sc_run;
  logic [8:0] irda_div;
  logic [8:0] sc_div;
  logic       irda_tick;
  logic       sc_tick;

  // each divider runs only in its own mode, so the shared value is inert
  // elsewhere; zero is reserved and simply stops the divider
  assign irda_run = HAS_PSC && special_reg[INFRARED_ENABLE_BIT]
                    && special_reg[INFRARED_LOW_POWER_BIT];
  assign sc_run   = HAS_PSC && special_reg[SMARTCARD_ENABLE_BIT];
  assign irda_div = {1'b0, presc_reg};
  // upper three bits dropped, value doubled
  assign sc_div   = {3'b000, presc_reg[SC_BITS-1:0], 1'b0};

  presc_divider u_irda_div (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_run     (irda_run),
    .i_divisor (irda_div),
    .o_tick    (irda_tick)
  );

  presc_divider u_sc_div (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_run     (sc_run),
    .i_divisor (sc_div),
    .o_tick    (sc_tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // registered outputs

  logic irda_tick_reg;
  logic sc_tick_reg;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irda_tick_reg <= 1'b0;
      sc_tick_reg   <= 1'b0;
    end else begin
      irda_tick_reg <= irda_tick;
      sc_tick_reg   <= sc_tick;
    end
  end

  assign o_rdata                      = rdata_reg;
  assign o_infrared_enable            = special_reg[INFRARED_ENABLE_BIT];
  assign o_infrared_low_power         = special_reg[INFRARED_LOW_POWER_BIT];
  assign o_smartcard_enable           = special_reg[SMARTCARD_ENABLE_BIT];
  assign o_parity_negative_ack_enable = special_reg[PARITY_NEGATIVE_ACK_ENABLE_BIT];
  assign o_single_wire_select         = special_reg[SINGLE_WIRE_SELECT_BIT];
  assign o_lin_enable                 = stopclk_reg[6];
  assign o_guard_time_value           = guard_reg;
  assign o_baud_div = {baud_hl_reg[7:4], baud_mid_reg, baud_hl_reg[3:0]};
  assign o_irda_lp_tick               = irda_tick_reg;
  assign o_smartcard_tick             = sc_tick_reg;

endmodule

`default_nettype wire

/* bench/uart_presc_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module uart_presc_checker
  import uart_presc_pkg::*;
(
  input wire logic       i_sys_clk,
  input wire logic       i_rst_n,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic [7:0] i_status,
  input wire logic       o_infrared_enable,
  input wire logic       o_infrared_low_power,
  input wire logic       o_smartcard_enable,
  input wire logic       o_irda_lp_tick,
  input wire logic       o_smartcard_tick
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  ////////////////////////////////////////
  logic [7:0] psc_reg, psc_next;
  logic [8:0] ir_gap_reg, ir_gap_next, sc_gap_reg, sc_gap_next;
  logic       ir_ok_reg, ir_ok_next, sc_ok_reg, sc_ok_next, hit;
  logic [1:0] hit_reg, hit_next;
  always_comb begin
    hit = i_wr && (i_addr == PRESC_OFS_I2 || i_addr == SPECIAL_CTRL_OFS);
    psc_next = (i_wr && i_addr == PRESC_OFS_I2) ? i_wdata : psc_reg;
    ir_gap_next = o_irda_lp_tick ? 9'h000 : ir_gap_reg + 9'h001;
    sc_gap_next = o_smartcard_tick ? 9'h000 : sc_gap_reg + 9'h001;
    hit_next = {hit_reg[0], hit};
    // a write spoils the ticks still in the two-stage pipeline and the
    // first gap after them, so those are skipped
    ir_ok_next = (hit || hit_reg != 2'h0) ? 1'b0
                                          : (o_irda_lp_tick | ir_ok_reg);
    sc_ok_next = (hit || hit_reg != 2'h0) ? 1'b0
                                          : (o_smartcard_tick | sc_ok_reg);
  end
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {hit_reg, psc_reg, ir_gap_reg, sc_gap_reg, ir_ok_reg, sc_ok_reg} <= '0;
    end else begin
      {hit_reg, psc_reg, ir_gap_reg, sc_gap_reg, ir_ok_reg, sc_ok_reg} <=
        {hit_next, psc_next, ir_gap_next, sc_gap_next, ir_ok_next,
         sc_ok_next};
    end
  end
  ////////////////////////////////////////
  chk_presc_read: assert property (
    i_rd && i_addr == PRESC_OFS_I2 |=> o_rdata == $past(psc_reg))
    else $error("prescaler read value wrong");
  chk_status_pass: assert property (
    i_rd && i_addr == STATUS_OFS |=> o_rdata == $past(i_status))
    else $error("status read value wrong");
  chk_unmapped_zero: assert property (
    i_rd && i_addr > PRESC_OFS_I2 |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_irda_period: assert property (
    o_irda_lp_tick && ir_ok_reg |-> ir_gap_reg == {1'b0, psc_reg} - 9'h001)
    else $error("low power clock period wrong");
  chk_sc_period: assert property (
    o_smartcard_tick && sc_ok_reg
      |-> sc_gap_reg == {3'h0, psc_reg[4:0], 1'b0} - 9'h001)
    else $error("smartcard clock period wrong");
  chk_irda_off: assert property (
    (!(o_infrared_enable && o_infrared_low_power))[*3] |-> !o_irda_lp_tick)
    else $error("low power clock while mode off");
  chk_sc_off: assert property (
    (!o_smartcard_enable)[*3] |-> !o_smartcard_tick)
    else $error("smartcard clock while mode off");
  chk_zero_quiet: assert property (
    (psc_reg == 8'h00)[*3] |-> !o_irda_lp_tick && !o_smartcard_tick)
    else $error("clock pulse with zero divisor");
  cover property (o_irda_lp_tick && ir_ok_reg);
  cover property (o_smartcard_tick && sc_ok_reg);
  cover property (i_rd && i_addr == PRESC_OFS_I2);
endmodule
`default_nettype wire

/* bench/tick_meter.sv */
`timescale 1ns/1ps
`default_nettype none
// far-side clock sink: measures the gap between prescaled pulses
module tick_meter (
  input  wire logic i_sys_clk,
  input  wire logic i_rst_n,
  input  wire logic i_tick,
  output var  int   o_period,
  output var  int   o_count
);
  int gap;
  // a period is only known once two pulses were seen
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gap      <= 0;
      o_period <= 0;
      o_count  <= 0;
    end else if (i_tick) begin
      gap      <= 0;
      o_period <= gap + 1;
      o_count  <= o_count + 1;
    end else begin
      gap <= gap + 1;
    end
  end
endmodule
`default_nettype wire

/* bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import uart_presc_pkg::*;
;
  logic       i_sys_clk, i_rst_n, i_wr, i_rd, ir_tick, sc_tick;
  logic [3:0] i_addr;
  logic [7:0] i_wdata, i_status, i_rx_data, o_rdata, lf;
  logic       ir_en, ir_lp, sc_en, parity_negative_ack_enable_en, sw_sel, lin_en;
  logic [7:0] gt_v;
  logic [15:0] baud_v;
  int         failures, n_compared, cyc, psc_m, c0, ir_p, ir_n, sc_p, sc_n;
  logic [7:0] ir_v [3] = '{8'h01, 8'h02, 8'hFF};
  logic [7:0] sc_v [4] = '{8'hE1, 8'h03, 8'h1F, 8'hA2};
  uart_presc_regs #(.INSTANCE(2)) dut (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_status(i_status), .i_rx_data(i_rx_data),
    .o_infrared_enable(ir_en), .o_infrared_low_power(ir_lp),
    .o_smartcard_enable(sc_en), .o_parity_negative_ack_enable(parity_negative_ack_enable_en),
    .o_single_wire_select(sw_sel), .o_lin_enable(lin_en),
    .o_guard_time_value(gt_v), .o_baud_div(baud_v),
    .o_irda_lp_tick(ir_tick), .o_smartcard_tick(sc_tick));
  tick_meter ir_m (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_tick(ir_tick), .o_period(ir_p), .o_count(ir_n));
  tick_meter sc_m (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_tick(sc_tick), .o_period(sc_p), .o_count(sc_n));
  ////////////////////////////////////////
  function automatic logic [7:0] lfsr_step(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
    if (a == PRESC_OFS_I2) psc_m = d;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    @(negedge i_sys_clk);
    check(o_rdata, exp);
  endtask
  // waits three pulses so the period is free of the reprogramming
  task automatic meas(input bit sc, input int exp);
    int n0;
    int other;
    // let ticks already in the pipeline land before counting
    repeat (3) @(posedge i_sys_clk);
    n0 = sc ? sc_n : ir_n;
    other = sc ? ir_n : sc_n;
    for (int i = 0; i < 3000 && (sc ? sc_n : ir_n) < n0 + 3; i++) begin
      @(posedge i_sys_clk);
    end
    @(negedge i_sys_clk);
    check(sc ? sc_p : ir_p, exp);
    check(sc ? ir_n : sc_n, other);
  endtask
  task automatic stop_test();
    $display("compared=%0d failures=%0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    i_sys_clk = 1'b0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 12000) begin
      failures++;
      stop_test();
    end
  end
  initial begin
    {i_rst_n, i_wr, i_rd, i_addr, i_wdata, i_rx_data} = '0;
    {failures, n_compared, cyc, psc_m} = '0;
    i_status = 8'hC0;
    lf = 8'h20;
    repeat (3) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    rd_chk(PRESC_OFS_I2, 8'h00);
    repeat (6) begin
      @(posedge i_sys_clk);
      lf = lfsr_step(lf);
      i_status <= lf;
      i_rx_data <= ~lf;
      rd_chk(STATUS_OFS, lf);
      rd_chk(DATA_OFS, ~lf);
      wr(PRESC_OFS_I2, lf ^ 8'h5A);
      rd_chk(PRESC_OFS_I2, psc_m[7:0]);
    end
    for (int a = 12; a < 16; a++) begin
      wr(a[3:0], 8'hFF);
      rd_chk(a[3:0], 8'h00);
    end
    rd_chk(PRESC_OFS_I2, psc_m[7:0]);
    // every mode bit at once; single-wire is absent on this instance
    wr(SPECIAL_CTRL_OFS, 8'hFF);
    rd_chk(SPECIAL_CTRL_OFS, SPECIAL_MASK_I2);
    check({ir_en, ir_lp, sc_en, parity_negative_ack_enable_en, sw_sel}, 5'h1E);
    wr(BAUD_MID_OFS, lf);
    wr(BAUD_HL_OFS, ~lf);
    wr(GUARD_OFS_I2, lf ^ 8'h3C);
    wr(STOP_CLK_CTRL_OFS, 8'hFF);
    @(negedge i_sys_clk);
    check(baud_v, {~lf[7:4], lf, ~lf[3:0]});
    check(gt_v, lf ^ 8'h3C);
    check(lin_en, 1'b1);
    rd_chk(STOP_CLK_CTRL_OFS, STOP_CLK_MASK);
    wr(SPECIAL_CTRL_OFS, 8'h06);
    for (int k = 0; k < 3; k++) begin
      wr(PRESC_OFS_I2, ir_v[k]);
      meas(1'b0, int'(ir_v[k]));
    end
    // infrared without low power leaves the divider idle
    wr(SPECIAL_CTRL_OFS, 8'h02);
    // ticks launched before the mode dropped may still arrive
    repeat (3) @(posedge i_sys_clk);
    c0 = ir_n;
    repeat (4 * psc_m) @(posedge i_sys_clk);
    check(ir_n, c0);
    wr(SPECIAL_CTRL_OFS, 8'h20);
    for (int k = 0; k < 4; k++) begin
      wr(PRESC_OFS_I2, sc_v[k]);
      meas(1'b1, 2 * int'(sc_v[k][4:0]));
    end
    wr(SPECIAL_CTRL_OFS, 8'h00);
    repeat (3) @(posedge i_sys_clk);
    c0 = sc_n;
    repeat (300) @(posedge i_sys_clk);
    check(sc_n, c0);
    stop_test();
  end
endmodule
bind uart_presc_regs uart_presc_checker chk (
  .i_sys_clk            (i_sys_clk),
  .i_rst_n              (i_rst_n),
  .i_addr               (i_addr),
  .i_wdata              (i_wdata),
  .i_wr                 (i_wr),
  .i_rd                 (i_rd),
  .o_rdata              (o_rdata),
  .i_status             (i_status),
  .o_infrared_enable    (o_infrared_enable),
  .o_infrared_low_power (o_infrared_low_power),
  .o_smartcard_enable   (o_smartcard_enable),
  .o_irda_lp_tick       (o_irda_lp_tick),
  .o_smartcard_tick     (o_smartcard_tick)
);
`default_nettype wire
